//--- core/nvm_access_ctrl.sv
// Purpose: byte access control for a small non-volatile data array
// Assumes: classic Wishbone slave, single 200 MHz clock, sync reset
// Notes: control register is reached only through the indirect window
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module nvm_access_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // wishbone slave
    input wire nvm_pkg::wb_req_s wb_req,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // interrupt controller side
    input wire logic irq_serviced,
    output logic irq_o,
    // status
    output logic nvm_busy
);
    import nvm_pkg::*;

    // true when the request addresses the given offset
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    // software-visible registers
    logic [ADDR_W-1:0] nvm_addr_reg_r; // target byte address
    logic [DATA_W-1:0] nvm_data_reg_r; // byte to store or byte read
    logic [7:0] bank_select_r; // bank pointer
    logic [7:0] indirect_pointer_one_r; // indirect window pointer
    logic write_permit_r; // control bit 3
    logic write_go_r; // control bit 2
    logic read_permit_r; // control bit 1
    logic read_go_r; // control bit 0
    logic nvm_irq_flag_r; // memory request flag
    logic nvm_irq_enable_r; // memory interrupt enable
    logic mfi_flag_r; // multi-function request flag
    logic mfi_enable_r; // multi-function enable
    logic global_irq_enable_r; // global enable

    // sequencer
    seq_e state_r; // current access phase
    logic [7:0] tick_cnt_r; // ticks elapsed in a write
    logic [1:0] rd_cnt_r; // clocks elapsed in a read
    logic [ADDR_W-1:0] wr_addr_r; // address latched at write start
    logic [DATA_W-1:0] wr_data_r; // data latched at write start

    // wires
    logic tick; // write timer pulse
    logic [DATA_W-1:0] arr_rd_data; // array read port
    logic write_done; // last tick of a write
    logic read_done; // last clock of a read
    logic bus_wr; // write takes effect this edge
    logic ctrl_open; // indirect window lands on control
    logic ctrl_wr; // bus write to control register
    logic wgo_req; // accepted write start
    logic rgo_req; // accepted read start
    logic [7:0] ctrl_val; // control register as read
    logic [7:0] irq_val; // interrupt register as read
    logic [7:0] rd_byte; // read mux output

    // write timer tick source, independent of register traffic
    nvm_tick_gen u_tick (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(tick)
    );

    // storage array
    nvm_array u_array (
        .ref_clk(ref_clk),
        .wr_en(write_done),
        .wr_addr(wr_addr_r),
        .wr_data(wr_data_r),
        .rd_addr(nvm_addr_reg_r),
        .rd_data(arr_rd_data)
    );

    // --- bus decode ---

    // a write lands on the edge where the master sees ack
    assign bus_wr = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack_o & wb_req.sel[0];

    // control is visible only at pointer 040H with bank one selected
    assign ctrl_open = (indirect_pointer_one_r == CTRL_LOC)
                     & (bank_select_r == CTRL_BANK); // see RQ8 see RQ13
    assign ctrl_wr = bus_wr & hit(wb_req.adr, OFF_IND) & ctrl_open;

    // write start needs permit already set before this write; see RQ3
    assign wgo_req = ctrl_wr & wb_req.dat[BIT_WGO] & write_permit_r
                   & (state_r == ST_IDLE);

    // read start needs read permit; a write request takes precedence
    assign rgo_req = ctrl_wr & wb_req.dat[BIT_RGO] & read_permit_r
                   & (state_r == ST_IDLE) & ~wgo_req; // see RQ18

    // completion strobes
    assign write_done = (state_r == ST_WRITE) & tick
                      & (tick_cnt_r == WRITE_TICKS - 8'h01); // see RQ21
    assign read_done = (state_r == ST_READ)
                     & (rd_cnt_r == READ_CLKS - 2'h1); // see RQ22

    // --- register read views ---

    // control fields at their fixed bit positions
    always_comb begin
        ctrl_val = 8'h00;
        ctrl_val[BIT_WPERMIT] = write_permit_r; // see RQ14
        ctrl_val[BIT_WGO] = write_go_r; // see RQ14
        ctrl_val[BIT_RPERMIT] = read_permit_r; // see RQ15
        ctrl_val[BIT_RGO] = read_go_r; // see RQ15
    end

    // interrupt fields
    always_comb begin
        irq_val = 8'h00;
        irq_val[BIT_NVM_FLAG] = nvm_irq_flag_r;
        irq_val[BIT_NVM_EN] = nvm_irq_enable_r;
        irq_val[BIT_MFI_FLAG] = mfi_flag_r;
        irq_val[BIT_MFI_EN] = mfi_enable_r;
        irq_val[BIT_GIE] = global_irq_enable_r;
    end

    // read mux; unmapped offsets and a closed window read zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit(wb_req.adr, OFF_ADDR)) begin
            rd_byte = {2'h0, nvm_addr_reg_r};
        end else if (hit(wb_req.adr, OFF_DATA)) begin
            rd_byte = nvm_data_reg_r;
        end else if (hit(wb_req.adr, OFF_BANK)) begin
            rd_byte = bank_select_r;
        end else if (hit(wb_req.adr, OFF_PTR)) begin
            rd_byte = indirect_pointer_one_r;
        end else if (hit(wb_req.adr, OFF_IND)) begin
            rd_byte = ctrl_open ? ctrl_val : 8'h00;
        end else if (hit(wb_req.adr, OFF_IRQ)) begin
            rd_byte = irq_val;
        end
    end

    // --- wishbone answer ---

    // one wait state: ack rises the cycle after the request, for one cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req.cyc & wb_req.stb & ~wb_ack_o;
        end
    end

    // read data captured with ack; upper lanes read zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req.cyc & wb_req.stb & ~wb_ack_o) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // --- bank zero registers ---

    // address register; six bits only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nvm_addr_reg_r <= RST_ADDR;
        end else if (bus_wr & hit(wb_req.adr, OFF_ADDR)) begin
            nvm_addr_reg_r <= wb_req.dat[ADDR_W-1:0]; // see RQ19
        end
    end

    // data register; a finished read overrides a same-edge bus write
    // so the byte software polls for is never lost
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nvm_data_reg_r <= RST_DATA;
        end else if (read_done) begin
            nvm_data_reg_r <= arr_rd_data; // see RQ22 see RQ18
        end else if (bus_wr & hit(wb_req.adr, OFF_DATA)) begin
            nvm_data_reg_r <= wb_req.dat[DATA_W-1:0];
        end
    end

    // bank pointer starts at zero so control is unreachable after reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bank_select_r <= RST_BANK; // see RQ8
        end else if (bus_wr & hit(wb_req.adr, OFF_BANK)) begin
            bank_select_r <= wb_req.dat[7:0];
        end
    end

    // indirect pointer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            indirect_pointer_one_r <= RST_PTR;
        end else if (bus_wr & hit(wb_req.adr, OFF_PTR)) begin
            indirect_pointer_one_r <= wb_req.dat[7:0];
        end
    end

    // --- control register ---

    // permit bits are plain storage; write permit clears at reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            write_permit_r <= 1'b0; // see RQ7
            read_permit_r <= 1'b0;
        end else if (ctrl_wr) begin
            write_permit_r <= wb_req.dat[BIT_WPERMIT]; // see RQ14
            read_permit_r <= wb_req.dat[BIT_RPERMIT]; // see RQ15
        end
    end

    // write-go: set only on an accepted start, cleared by the sequencer;
    // software writing zero cannot abort a cycle already running
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            write_go_r <= 1'b0;
        end else if (wgo_req) begin
            write_go_r <= 1'b1; // see RQ3
        end else if (write_done) begin
            write_go_r <= 1'b0; // see RQ5
        end
    end

    // read-go: same shape as write-go
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            read_go_r <= 1'b0;
        end else if (rgo_req) begin
            read_go_r <= 1'b1; // see RQ18
        end else if (read_done) begin
            read_go_r <= 1'b0; // see RQ22
        end
    end

    // --- access sequencer ---

    // idle, timed write, or short read
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (wgo_req) begin
                        state_r <= ST_WRITE;
                    end else if (rgo_req) begin
                        state_r <= ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (write_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (read_done) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // write length counted in timer ticks, not system clocks; the start
    // lands at a random phase of the tick, so length varies slightly
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tick_cnt_r <= 8'h00;
        end else if (wgo_req) begin
            tick_cnt_r <= 8'h00;
        end else if ((state_r == ST_WRITE) & tick) begin
            tick_cnt_r <= tick_cnt_r + 8'h01; // see RQ4 see RQ21
        end
    end

    // read length in system clocks
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_cnt_r <= 2'h0;
        end else if (rgo_req) begin
            rd_cnt_r <= 2'h0;
        end else if (state_r == ST_READ) begin
            rd_cnt_r <= rd_cnt_r + 2'h1;
        end
    end

    // latch address and byte at start so later bus writes cannot
    // corrupt a write in flight
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_addr_r <= RST_ADDR;
            wr_data_r <= RST_DATA;
        end else if (wgo_req) begin
            wr_addr_r <= nvm_addr_reg_r;
            wr_data_r <= nvm_data_reg_r;
        end
    end

    // --- interrupt flags and enables ---

    // enables are plain storage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nvm_irq_enable_r <= 1'b0;
            mfi_enable_r <= 1'b0;
            global_irq_enable_r <= 1'b0;
        end else if (bus_wr & hit(wb_req.adr, OFF_IRQ)) begin
            nvm_irq_enable_r <= wb_req.dat[BIT_NVM_EN];
            mfi_enable_r <= wb_req.dat[BIT_MFI_EN];
            global_irq_enable_r <= wb_req.dat[BIT_GIE];
        end
    end

    // memory flag: set at write end, cleared only by software;
    // the set wins over a same-edge software clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nvm_irq_flag_r <= 1'b0;
        end else if (write_done) begin
            nvm_irq_flag_r <= 1'b1; // see RQ9
        end else if (bus_wr & hit(wb_req.adr, OFF_IRQ)) begin
            nvm_irq_flag_r <= wb_req.dat[BIT_NVM_FLAG]; // see RQ11
        end
    end

    // multi-function flag: set at write end, cleared by service or
    // software; the set again wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mfi_flag_r <= 1'b0;
        end else if (write_done) begin
            mfi_flag_r <= 1'b1; // see RQ9
        end else if (irq_serviced) begin
            mfi_flag_r <= 1'b0; // see RQ11
        end else if (bus_wr & hit(wb_req.adr, OFF_IRQ)) begin
            mfi_flag_r <= wb_req.dat[BIT_MFI_FLAG];
        end
    end

    // interrupt request toward the core needs every enable
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= nvm_irq_flag_r & nvm_irq_enable_r & mfi_flag_r
                   & mfi_enable_r & global_irq_enable_r; // see RQ10
        end
    end

    // busy mirrors a cycle in progress; useful to gate low-power entry
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nvm_busy <= 1'b0;
        end else begin
            nvm_busy <= wgo_req | rgo_req
                      | ((state_r != ST_IDLE) & ~write_done & ~read_done);
        end
    end

endmodule : nvm_access_ctrl

//--- core/nvm_array.sv
// Purpose: sixty-four byte storage array for the non-volatile data
// Assumes: one write port, one combinational read port
// Notes: contents have no reset, as a real cell keeps its charge
`timescale 1ns/1ps
module nvm_array (
    // clock
    input wire logic ref_clk,
    // write port
    input wire logic wr_en,
    input wire logic [nvm_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [nvm_pkg::DATA_W-1:0] wr_data,
    // read port
    input wire logic [nvm_pkg::ADDR_W-1:0] rd_addr,
    output logic [nvm_pkg::DATA_W-1:0] rd_data
);
    import nvm_pkg::*;

    logic [DATA_W-1:0] mem_r [DEPTH]; // byte cells, see RQ19

    // store a byte when the write cycle completes
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_addr];

endmodule : nvm_array

//--- core/nvm_pkg.sv
// Purpose: shared constants and types for the non-volatile byte access block
// Assumes: 32-bit classic Wishbone, registers in the low byte lane
// Notes: all offsets, field positions, counts and the address, data, bank and pointer resets live here
//
// How it works
// RQ1: software loads address and data before writing
// RQ2: software sets write_permit, then write-go next
// RQ3: write-go ignored unless write_permit already set
// RQ4: write timed by independent tick timer
// RQ5: hardware clears write-go when write ends
// RQ6: software masks global interrupt around start
// RQ7: reset clears write_permit
// RQ8: reset zeroes bank_select; control only bank one
// RQ9: write end sets memory and multi-function flags
// RQ10: interrupt needs all three enables set
// RQ11: service clears multi-function flag only
// RQ12: software never sleeps during a cycle
// RQ13: control reached via pointer 040H, bank 01H
// RQ14: write_permit bit 3, write-go bit 2
// RQ15: read_permit bit 1, read-go bit 0
// RQ16: software polls read-go before taking data
// RQ17: software keeps permit and bank at zero
// RQ18: read-go needs read_permit; data held after read
// RQ19: sixty-four bytes, six-bit address, eight-bit data
// RQ20: software never sets both go bits
// RQ21: write lasts a parameterised tick count
// RQ22: read finishes in fixed clocks, data first
package nvm_pkg;

    // wishbone request bundle from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // array geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int DEPTH = 64;

    // byte offsets on the bus
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_BANK = 8'h08;
    localparam logic [7:0] OFF_PTR = 8'h0c;
    localparam logic [7:0] OFF_IND = 8'h10;
    localparam logic [7:0] OFF_IRQ = 8'h14;

    // where the control register sits behind the indirect window
    localparam logic [7:0] CTRL_LOC = 8'h40;
    localparam logic [7:0] CTRL_BANK = 8'h01;

    // control register fields
    localparam int BIT_WPERMIT = 3;
    localparam int BIT_WGO = 2;
    localparam int BIT_RPERMIT = 1;
    localparam int BIT_RGO = 0;

    // interrupt register fields
    localparam int BIT_NVM_FLAG = 0;
    localparam int BIT_NVM_EN = 1;
    localparam int BIT_MFI_FLAG = 2;
    localparam int BIT_MFI_EN = 3;
    localparam int BIT_GIE = 4;

    // reset values
    localparam logic [5:0] RST_ADDR = 6'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [7:0] RST_PTR = 8'h00;

    // timing: clocks per write timer tick, ticks per write, clocks per read
    localparam int TICK_DIV = 50;
    localparam logic [7:0] WRITE_TICKS = 8'h28;
    localparam logic [1:0] READ_CLKS = 2'h2;

    // access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ
    } seq_e;

endpackage : nvm_pkg

//--- core/nvm_tick_gen.sv
// Purpose: free-running tick source that paces the write timer
// Assumes: single clock, tick is a one-cycle enable pulse
// Notes: runs regardless of bus traffic, so write length is not tied to it
`timescale 1ns/1ps
module nvm_tick_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // tick out
    output logic tick
);
    import nvm_pkg::*;

    logic [7:0] div_r; // divider count

    // count to the divide ratio and pulse once per wrap
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_r <= 8'h00;
            tick <= 1'b0;
        end else if (div_r == 8'(TICK_DIV - 1)) begin
            div_r <= 8'h00;
            tick <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            tick <= 1'b0;
        end
    end

endmodule : nvm_tick_gen

//--- testbench/nvm_access_ctrl_checker.sv
// Purpose: concurrent checks on the access controller's ports
// Assumes: one clock, sync active-high reset, classic single-cycle master
// Notes: internal flags are hidden, so irq checks lean on bus traffic
`timescale 1ns/1ps
module nvm_access_ctrl_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // bus
    input wire nvm_pkg::wb_req_s wb_req,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // interrupt and status
    input wire logic irq_serviced,
    input wire logic irq_o,
    input wire logic nvm_busy
);
    import nvm_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [11:0] busy_len_r; // cycles the current access has run
    logic irq_wr; // a write to the irq register lands now
    logic go_wr; // a write to the control window lands now
    logic unmapped; // offset outside the register map
    assign irq_wr = wb_ack_o && wb_req.we && (wb_req.adr == OFF_IRQ);
    assign go_wr = wb_ack_o && wb_req.we && (wb_req.adr == OFF_IND);
    assign unmapped = !(wb_req.adr inside {OFF_ADDR, OFF_DATA, OFF_BANK, OFF_PTR, OFF_IND,
        OFF_IRQ});
    // count busy length; cleared while idle so each access starts from zero
    always_ff @(posedge ref_clk) begin
        if (srst || !nvm_busy) begin
            busy_len_r <= 12'h000;
        end else begin
            busy_len_r <= busy_len_r + 12'h001;
        end
    end
    sequence s_req;
        wb_req.cyc && wb_req.stb && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_lat;
        s_req |=> s_ack_pulse;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
    property p_ack_quiet;
        !(wb_req.cyc && wb_req.stb) |=> !wb_ack_o;
    endproperty
    a_ack_quiet: assert property (p_ack_quiet) else $error("ack without request");
    property p_dat_upper;
        wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000);
    endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
    property p_unmapped;
        wb_ack_o && !wb_req.we && unmapped |-> (wb_dat_o == 32'h00000000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_busy_start;
        $rose(nvm_busy) |-> $past(go_wr) || $past(go_wr, 2);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("access began unasked");
    property p_busy_len;
        $fell(nvm_busy) |-> (busy_len_r <= 12'h004) ||
            ((busy_len_r >= 12'd1940) && (busy_len_r <= 12'd2010));
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("access length wrong");
    property p_irq_cause;
        $rose(irq_o) |-> $past(nvm_busy) || $past(nvm_busy, 2) || $past(irq_wr) ||
            $past(irq_wr, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
    property p_irq_clear;
        irq_serviced && !nvm_busy && !wb_req.cyc |=> ##1 !irq_o;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("service left irq high");
endmodule : nvm_access_ctrl_checker

bind nvm_access_ctrl nvm_access_ctrl_checker u_checker (
    .ref_clk(ref_clk), .srst(srst), .wb_req(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .irq_serviced(irq_serviced), .irq_o(irq_o), .nvm_busy(nvm_busy)
);

//--- testbench/nvm_access_ctrl_tb_top.sv
// Purpose: directed bench for the non-volatile byte access controller
// Assumes: classic wishbone master tasks, one 200 MHz clock
// Notes: one full write is timed, so the run is a few thousand clocks
`timescale 1ns/1ps
module nvm_access_ctrl_tb_top;
    import nvm_pkg::*;
    logic ref_clk; // 200 MHz
    logic srst; // sync reset
    wb_req_s wb_req; // bus request
    logic irq_serviced; // service pulse
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic irq_o;
    logic nvm_busy;
    int mismatches;
    int comparisons;
    int cycles; // cycle count, also the hang guard
    int start; // cycle stamp of an access start
    logic [31:0] rd; // data of the last bus read
    nvm_access_ctrl dut (
        .ref_clk(ref_clk), .srst(srst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .irq_serviced(irq_serviced), .irq_o(irq_o), .nvm_busy(nvm_busy)
    );
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // hang guard: the whole run needs well under this
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t data %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag
    // one classic cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: dat};
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        // a missing ack is a failure, not a silent release
        if (n >= 50) begin
            mismatches++;
            $display("ERROR %0t no ack on bus", $time);
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask : wb_xfer
    // poll the control window until a go bit reads back low
    task automatic poll_ctrl(input int bitn);
        do wb_xfer(1'b0, OFF_IND, 32'h0); while (rd[bitn] !== 1'b0);
    endtask : poll_ctrl
    task automatic t_reset_values();
        wb_xfer(1'b0, OFF_BANK, 32'h0);
        chk(rd, 32'h00);
        wb_xfer(1'b1, OFF_PTR, {24'h0, CTRL_LOC});
        wb_xfer(1'b1, OFF_IND, 32'h08);
        wb_xfer(1'b0, OFF_IND, 32'h0);
        chk(rd, 32'h00);
        wb_xfer(1'b1, OFF_BANK, {24'h0, CTRL_BANK});
        wb_xfer(1'b0, OFF_IND, 32'h0);
        chk(rd, 32'h00);
        wb_xfer(1'b1, OFF_ADDR, 32'hff);
        wb_xfer(1'b0, OFF_ADDR, 32'h0);
        chk(rd, 32'h3f);
        wb_xfer(1'b1, 8'h18, 32'hff);
        wb_xfer(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h00);
    endtask : t_reset_values
    task automatic t_write_refused();
        wb_xfer(1'b1, OFF_IND, 32'h04);
        wb_xfer(1'b0, OFF_IND, 32'h0);
        chk(rd, 32'h00);
        chk_flag(nvm_busy, 1'b0);
        wb_xfer(1'b1, OFF_IND, 32'h0c);
        wb_xfer(1'b0, OFF_IND, 32'h0);
        chk(rd, 32'h08);
        wb_xfer(1'b1, OFF_IND, 32'h00);
    endtask : t_write_refused
    task automatic t_write_cycle();
        wb_xfer(1'b1, OFF_IRQ, 32'h00);
        wb_xfer(1'b1, OFF_DATA, 32'ha5);
        wb_xfer(1'b1, OFF_IND, 32'h08);
        wb_xfer(1'b1, OFF_IND, 32'h0c);
        start = cycles;
        wb_xfer(1'b0, OFF_IND, 32'h0);
        chk(rd, 32'h0c);
        chk_flag(nvm_busy, 1'b1);
        wb_xfer(1'b1, OFF_IRQ, 32'h10);
        poll_ctrl(BIT_WGO);
        chk_flag((cycles - start) >= 1950 && (cycles - start) <= 2020, 1'b1);
        wb_xfer(1'b0, OFF_IRQ, 32'h0);
        chk(rd, 32'h15);
        chk_flag(irq_o, 1'b0);
    endtask : t_write_cycle
    task automatic t_irq();
        int masks[3] = '{32'h1d, 32'h17, 32'h0f};
        wb_xfer(1'b1, OFF_IRQ, 32'h1f);
        repeat (2) @(posedge ref_clk);
        chk_flag(irq_o, 1'b1);
        foreach (masks[i]) begin
            wb_xfer(1'b1, OFF_IRQ, masks[i]);
            repeat (2) @(posedge ref_clk);
            chk_flag(irq_o, 1'b0);
        end
        wb_xfer(1'b1, OFF_IRQ, 32'h1f);
        @(posedge ref_clk);
        irq_serviced <= 1'b1;
        @(posedge ref_clk);
        irq_serviced <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_flag(irq_o, 1'b0);
        wb_xfer(1'b0, OFF_IRQ, 32'h0);
        chk(rd, 32'h1b);
        wb_xfer(1'b1, OFF_IRQ, 32'h1a);
        wb_xfer(1'b0, OFF_IRQ, 32'h0);
        chk(rd, 32'h1a);
    endtask : t_irq
    task automatic t_read();
        wb_xfer(1'b1, OFF_DATA, 32'h00);
        wb_xfer(1'b1, OFF_IND, 32'h01);
        wb_xfer(1'b0, OFF_IND, 32'h0);
        chk(rd, 32'h00);
        wb_xfer(1'b1, OFF_IND, 32'h02);
        wb_xfer(1'b1, OFF_IND, 32'h03);
        start = cycles;
        poll_ctrl(BIT_RGO);
        chk_flag((cycles - start) <= 12, 1'b1);
        wb_xfer(1'b0, OFF_DATA, 32'h0);
        chk(rd, 32'ha5);
        wb_xfer(1'b1, OFF_IND, 32'h00);
        wb_xfer(1'b1, OFF_BANK, 32'h00);
        wb_xfer(1'b0, OFF_DATA, 32'h0);
        chk(rd, 32'ha5);
    endtask : t_read
    initial begin
        srst = 1'b1;
        wb_req = '0;
        irq_serviced = 1'b0;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset_values();
        t_write_refused();
        t_write_cycle();
        t_irq();
        t_read();
        print_verdict();
    end
endmodule : nvm_access_ctrl_tb_top
